// ---- common/dcw_consts.svh ----
/*
 * Object indices, control word bit positions, reset values and mode codes
 * of the drive control word decoder.
 * Assumes inclusion by bare name from any file that needs the numbers.
 */
`ifndef DCW_CONSTS_SVH
`define DCW_CONSTS_SVH

// Object indices of axis A; axis B adds the axis offset
`define DCW_IDX_ERR        16'h603F
`define DCW_IDX_CTRL       16'h6040
`define DCW_IDX_STAT       16'h6041
`define DCW_AXIS_B_OFS     16'h0800

// Reset values
`define DCW_ERR_RST        16'h0000
`define DCW_CTRL_RST       16'h0000

// Control word bit positions
`define DCW_B_SWON         0
`define DCW_B_ENVOLT       1
`define DCW_B_QSTOP        2
`define DCW_B_ENOP         3
`define DCW_B_MS4          4
`define DCW_B_MS5          5
`define DCW_B_MS6          6
`define DCW_B_FRST         7
`define DCW_B_HALT         8
`define DCW_B_MS9          9
`define DCW_B_PTL          11
`define DCW_B_NTL          12

// Operation mode codes as presented on the mode input
`define DCW_MODE_PP        8'h01
`define DCW_MODE_PV        8'h03
`define DCW_MODE_PT        8'h04
`define DCW_MODE_HM        8'h06
`define DCW_MODE_IP        8'h07
`define DCW_MODE_CSP       8'h08
`define DCW_MODE_CSV       8'h09
`define DCW_MODE_CST       8'h0A

`endif

// ---- common/dcw_pkg.sv ----
/*
 * Types of the drive control word decoder: state commands, the queue
 * state of profile position and the packed state of the decoder.
 * Assumes nothing of its surroundings.
 */
package dcw_pkg;

   // Drive state command decoded from bits 3..0
   typedef enum logic [2:0] {
      CMD_NONE     = 3'h0,
      CMD_DIS_VOLT = 3'h1,
      CMD_QSTOP    = 3'h2,
      CMD_SHUTDOWN = 3'h3,
      CMD_SWITCHON = 3'h4,
      CMD_ENOP     = 3'h5
   } dcw_cmd_t;

   // Profile position set point queue, Gray along idle -> queued
   typedef enum logic [1:0] {
      PP_IDLE   = 2'b00,
      PP_QUEUED = 2'b01
   } dcw_pp_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] err;
      logic [15:0] rdata;
      logic        ack;
      logic        nak;
      dcw_cmd_t    cmd;
      logic        fault_rst;
      logic        ptl;
      logic        ntl;
      logic        halt;
      dcw_pp_t     pp;
      logic        q_rel;
      logic        q_chain;
      logic        pp_start;
      logic        pp_rel;
      logic        pp_chain;
      logic        hm_run;
      logic        ip_en;
   } dcw_state_t;

endpackage

// ---- common/dcw_edge_if.sv ----
/*
 * Carrier between the decoder and its edge detector: the write strobe,
 * the watched bits of the written word and the rising edges found.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/100ps
`default_nettype none
interface dcw_edge_if #(parameter int W = 2);
   logic         wr;
   logic [W-1:0] data;
   logic [W-1:0] rise;
   modport src (output wr, output data, input rise);
   modport det (input wr, input data, output rise);
endinterface
`default_nettype wire

// ---- verilog/dcw_edge_det.sv ----
/*
 * Rising edge detector over written words: each bit reports 0 to 1 when
 * a newly written value is compared with the value received before.
 * Assumes the write strobe is a one-cycle pulse in the clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module dcw_edge_det #(
   parameter int W = 2
) (
   input  wire logic ref_clk_i,
   input  wire logic nrst_i,
   dcw_edge_if.det   eif
);
   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] rise;
   } dcw_edge_st_t;

   dcw_edge_st_t st;
   dcw_edge_st_t next_st;

   if (W < 1) begin : g_chk
      $error("dcw_edge_det: W must be at least 1");
   end

   // Edges only count on a write; a held level never repeats the pulse
   always_comb begin
      next_st      = st;
      next_st.rise = '0;
      if (eif.wr) begin
         next_st.rise = eif.data & ~st.prev;
         next_st.prev = eif.data;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign eif.rise = st.rise;
endmodule
`default_nettype wire

// ---- verilog/dcw_decoder.sv ----
/*
 * Drive control word decoder for one axis: holds the control word and
 * the last error code objects, serves object reads and writes, and turns
 * the control word into state commands, fault reset, torque limit enables
 * and the mode-specific motion controls.
 * Assumes object accesses arrive as one-cycle strobes synchronous to the
 * clock, and that the drive logic supplies mode, status and error events.
 */
// Notes on behaviour
// - Read-only 16-bit last error code object, zero after reset.
// - Read/write 16-bit control word per axis, zero after reset.
// - Fault reset only on a 0 to 1 change of bit 7.
// - Bit 11 high enables the positive torque limit, low disables it.
// - Bit 12 high enables the negative torque limit, low disables it.
// - Bit 7 low: decode disable voltage, quick stop, shutdown, switch on.
// - Bits 3..0 all high with bit 7 low: switch on and enable.
// - Profile position: bit 4 rise, bits 5, 9 low queue until reached.
// - Profile position: bit 4 rise with bit 5 high starts at once.
// - Bit 4 rise, bit 9 high, bit 5 low: keep speed, then next.
// - Profile position: bit 6 selects absolute or relative target.
// - Profile position: bit 8 high halts the axis, low lets it run.
// - Homing runs while bit 4 high; bits 5, 6, 9 reserved.
// - Homing, interpolation, profile velocity/torque: bit 8 halts.
// - Interpolation enabled by bit 4 only while bit 8 is low.
// - Cyclic modes: master holds bits 4, 5, 6, 9 low; bit 8 low runs.
// - Cyclic modes: bit 8 high halts the axis.
// - Status object is readable beside the control word.
`timescale 1ns/100ps
`default_nettype none
`include "dcw_consts.svh"
module dcw_decoder #(
   parameter logic [15:0] AXIS_OFS = 16'h0000,
   parameter int          CW_W     = 16
) (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        obj_wr_i,
   input  wire logic        obj_rd_i,
   input  wire logic [15:0] obj_idx_i,
   input  wire logic [15:0] obj_wdata_i,
   output logic      [15:0] obj_rdata_o,
   output logic             obj_ack_o,
   output logic             obj_nak_o,
   input  wire logic [7:0]  op_mode_i,
   input  wire logic [15:0] status_i,
   input  wire logic        err_set_i,
   input  wire logic [15:0] err_code_i,
   input  wire logic        target_reached_i,
   output logic      [15:0] ctrl_word_o,
   output logic      [2:0]  state_cmd_o,
   output logic             fault_reset_o,
   output logic             pos_tlim_en_o,
   output logic             neg_tlim_en_o,
   output logic             halt_o,
   output logic             pp_start_o,
   output logic             pp_relative_o,
   output logic             pp_chain_o,
   output logic             pp_queued_o,
   output logic             homing_run_o,
   output logic             interp_en_o
);
   localparam int RISE_MS4  = 0;
   localparam int RISE_FRST = 1;

   if (CW_W != 16) begin : g_chk_w
      $error("dcw_decoder: control word must be 16 bits wide");
   end
   if (AXIS_OFS != 16'h0000 && AXIS_OFS != `DCW_AXIS_B_OFS) begin : g_chk_a
      $error("dcw_decoder: AXIS_OFS must select axis A or axis B");
   end

   dcw_pkg::dcw_state_t st;
   dcw_pkg::dcw_state_t next_st;

   logic [15:0] idx_err;
   logic [15:0] idx_ctrl;
   logic [15:0] idx_stat;
   logic        wr_ctrl;
   logic        mode_pp;
   logic        mode_hm;
   logic        mode_ip;
   logic        mode_cs;
   logic        mode_pvt;
   logic        mode_known;
   logic [1:0]  rise;

   // Object indices of this axis
   assign idx_err  = `DCW_IDX_ERR + AXIS_OFS;
   assign idx_ctrl = `DCW_IDX_CTRL + AXIS_OFS;
   assign idx_stat = `DCW_IDX_STAT + AXIS_OFS;
   assign wr_ctrl  = obj_wr_i && (obj_idx_i == idx_ctrl);

   // Mode classes
   assign mode_pp  = (op_mode_i == `DCW_MODE_PP);
   assign mode_hm  = (op_mode_i == `DCW_MODE_HM);
   assign mode_ip  = (op_mode_i == `DCW_MODE_IP);
   assign mode_cs  = (op_mode_i == `DCW_MODE_CSP) ||
                     (op_mode_i == `DCW_MODE_CSV) ||
                     (op_mode_i == `DCW_MODE_CST);
   assign mode_pvt = (op_mode_i == `DCW_MODE_PV) ||
                     (op_mode_i == `DCW_MODE_PT);
   assign mode_known = mode_pp || mode_hm || mode_ip || mode_cs || mode_pvt;

   // Edge detector on bits 4 and 7 of each written control word
   dcw_edge_if #(.W(2)) eif ();

   assign eif.wr   = wr_ctrl;
   assign eif.data = {obj_wdata_i[`DCW_B_FRST], obj_wdata_i[`DCW_B_MS4]};
   assign rise     = eif.rise;

   dcw_edge_det #(.W(2)) u_edge (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .eif       (eif)
   );

   // Object access, command decode and set point queue
   always_comb begin
      next_st           = st;
      next_st.ack       = 1'b0;
      next_st.nak       = 1'b0;
      next_st.fault_rst = 1'b0;
      next_st.pp_start  = 1'b0;

      // Writes win over a read in the same cycle; only the control word
      // is writable, so a write anywhere else is refused
      if (obj_wr_i) begin
         if (obj_idx_i == idx_ctrl) begin
            next_st.ctrl = obj_wdata_i;
            next_st.ack  = 1'b1;
         end else begin
            next_st.nak  = 1'b1;
         end
      end else if (obj_rd_i) begin
         next_st.ack = 1'b1;
         if (obj_idx_i == idx_ctrl) begin
            next_st.rdata = st.ctrl;
         end else if (obj_idx_i == idx_err) begin
            next_st.rdata = st.err;
         end else if (obj_idx_i == idx_stat) begin
            next_st.rdata = status_i;
         end else begin
            next_st.rdata = 16'h0000;
            next_st.ack   = 1'b0;
            next_st.nak   = 1'b1;
         end
      end

      // Last error code follows the drive's error events
      if (err_set_i) begin
         next_st.err = err_code_i;
      end

      // Fault reset fires once per rising edge, never on a held level
      next_st.fault_rst = rise[RISE_FRST];

      // Torque limit enables are plain levels; bits 10 and 13..15 unused
      next_st.ptl = st.ctrl[`DCW_B_PTL];
      next_st.ntl = st.ctrl[`DCW_B_NTL];

      // State command; fault reset high suppresses the command
      if (st.ctrl[`DCW_B_FRST]) begin
         next_st.cmd = dcw_pkg::CMD_NONE;
      end else if (!st.ctrl[`DCW_B_ENVOLT]) begin
         next_st.cmd = dcw_pkg::CMD_DIS_VOLT;
      end else if (!st.ctrl[`DCW_B_QSTOP]) begin
         next_st.cmd = dcw_pkg::CMD_QSTOP;
      end else if (!st.ctrl[`DCW_B_SWON]) begin
         next_st.cmd = dcw_pkg::CMD_SHUTDOWN;
      end else if (!st.ctrl[`DCW_B_ENOP]) begin
         next_st.cmd = dcw_pkg::CMD_SWITCHON;
      end else begin
         next_st.cmd = dcw_pkg::CMD_ENOP;
      end

      // Halt applies in every mode the decoder knows; in cyclic modes
      // bit 8 low means execute or continue
      next_st.halt = mode_known &&
                     st.ctrl[`DCW_B_HALT];

      // Homing and interpolation are levels gated by halt; the reserved
      // bits 5, 6 and 9 are never looked at in these modes
      next_st.hm_run = mode_hm && st.ctrl[`DCW_B_MS4] &&
                       !st.ctrl[`DCW_B_HALT];
      next_st.ip_en  = mode_ip && st.ctrl[`DCW_B_MS4] &&
                       !st.ctrl[`DCW_B_HALT];

      // Cyclic and profile velocity/torque modes take only halt here;
      // bits 4, 5, 6 and 9 are left to the master to hold low

      // Profile position set point handling
      if (!mode_pp) begin
         next_st.pp       = dcw_pkg::PP_IDLE;
         next_st.q_chain  = 1'b0;
         next_st.pp_chain = 1'b0;
      end else if (rise[RISE_MS4]) begin
         // A new set point; bit 6 fixes how the target is read
         if (st.ctrl[`DCW_B_MS5] || (target_reached_i &&
             st.pp == dcw_pkg::PP_IDLE)) begin
            next_st.pp_start = 1'b1;
            next_st.pp_rel   = st.ctrl[`DCW_B_MS6];
            next_st.pp_chain = 1'b0;
            next_st.pp       = dcw_pkg::PP_IDLE;
         end else begin
            next_st.pp      = dcw_pkg::PP_QUEUED;
            next_st.q_rel   = st.ctrl[`DCW_B_MS6];
            next_st.q_chain = st.ctrl[`DCW_B_MS9];
            // Chain level shows as soon as the set point is queued
            next_st.pp_chain = st.ctrl[`DCW_B_MS9];
         end
      end else if (st.pp == dcw_pkg::PP_QUEUED && target_reached_i) begin
         // Queued set point released once the current target is reached
         next_st.pp_start = 1'b1;
         next_st.pp_rel   = st.q_rel;
         next_st.pp_chain = st.q_chain;
         next_st.pp       = dcw_pkg::PP_IDLE;
      end else if (st.pp == dcw_pkg::PP_QUEUED) begin
         // Chained moves keep profile speed through the current target
         next_st.pp_chain = st.q_chain;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st      <= '0;
         st.ctrl <= `DCW_CTRL_RST;
         st.err  <= `DCW_ERR_RST;
         st.cmd  <= dcw_pkg::CMD_NONE;
         st.pp   <= dcw_pkg::PP_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign obj_rdata_o   = st.rdata;
   assign obj_ack_o     = st.ack;
   assign obj_nak_o     = st.nak;
   assign ctrl_word_o   = st.ctrl;
   assign state_cmd_o   = st.cmd;
   assign fault_reset_o = st.fault_rst;
   assign pos_tlim_en_o = st.ptl;
   assign neg_tlim_en_o = st.ntl;
   assign halt_o        = st.halt;
   assign pp_start_o    = st.pp_start;
   assign pp_relative_o = st.pp_rel;
   assign pp_chain_o    = st.pp_chain;
   assign pp_queued_o   = st.pp[0]; // Only the queued code has bit 0 set
   assign homing_run_o  = st.hm_run;
   assign interp_en_o   = st.ip_en;

   // Checks on the decoder's own outputs
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_err_latch;
      err_set_i && !(obj_rd_i && obj_idx_i == idx_err)
      ##1 (obj_rd_i && !obj_wr_i && obj_idx_i == idx_err && !err_set_i)
      |=> obj_ack_o && obj_rdata_o == $past(err_code_i, 2);
   endproperty
   a_err_latch: assert property (p_err_latch)
      else $error("last error code not returned on read");

   property p_ctrl_write;
      obj_wr_i && obj_idx_i == idx_ctrl
      |=> obj_ack_o && ctrl_word_o == $past(obj_wdata_i);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control word write not stored");

   property p_fault_edge;
      obj_wr_i && obj_idx_i == idx_ctrl && obj_wdata_i[`DCW_B_FRST] &&
      !ctrl_word_o[`DCW_B_FRST] |=> ##1 fault_reset_o;
   endproperty
   a_fault_edge: assert property (p_fault_edge)
      else $error("fault reset missed a rising bit 7");

   property p_fault_level;
      fault_reset_o |-> $past(ctrl_word_o[`DCW_B_FRST]) &&
                        !$past(ctrl_word_o[`DCW_B_FRST], 2);
   endproperty
   a_fault_level: assert property (p_fault_level)
      else $error("fault reset without a rising bit 7");

   property p_ptl;
      ##1 pos_tlim_en_o == $past(ctrl_word_o[`DCW_B_PTL]);
   endproperty
   a_ptl: assert property (p_ptl)
      else $error("positive torque limit enable wrong");

   property p_ntl;
      ##1 neg_tlim_en_o == $past(ctrl_word_o[`DCW_B_NTL]);
   endproperty
   a_ntl: assert property (p_ntl)
      else $error("negative torque limit enable wrong");

   property p_dis_volt;
      !ctrl_word_o[`DCW_B_FRST] && !ctrl_word_o[`DCW_B_ENVOLT]
      |=> state_cmd_o == dcw_pkg::CMD_DIS_VOLT;
   endproperty
   a_dis_volt: assert property (p_dis_volt)
      else $error("disable voltage not decoded");

   property p_enop;
      !ctrl_word_o[`DCW_B_FRST] && ctrl_word_o[3:0] == 4'hF
      |=> state_cmd_o == dcw_pkg::CMD_ENOP;
   endproperty
   a_enop: assert property (p_enop)
      else $error("enable operation not decoded");

   property p_pp_now;
      mode_pp && rise[RISE_MS4] && ctrl_word_o[`DCW_B_MS5]
      |=> pp_start_o && !pp_queued_o;
   endproperty
   a_pp_now: assert property (p_pp_now)
      else $error("immediate set point did not start");

   property p_pp_wait;
      mode_pp && pp_queued_o && !target_reached_i && !rise[RISE_MS4]
      |=> !pp_start_o && pp_queued_o;
   endproperty
   a_pp_wait: assert property (p_pp_wait)
      else $error("queued set point started before target reached");

   property p_homing;
      mode_hm |=> homing_run_o == ($past(ctrl_word_o[`DCW_B_MS4]) &&
                                   !$past(ctrl_word_o[`DCW_B_HALT]));
   endproperty
   a_homing: assert property (p_homing)
      else $error("homing run level wrong");

   property p_ip_halt;
      mode_ip && ctrl_word_o[`DCW_B_HALT] |=> !interp_en_o && halt_o;
   endproperty
   a_ip_halt: assert property (p_ip_halt)
      else $error("interpolation not stopped by halt");

   // Main scenarios
   c_fault: cover property (fault_reset_o);
   c_queue: cover property (pp_queued_o ##[1:20] pp_start_o);
   c_chain: cover property (pp_chain_o && pp_start_o);
   c_enop:  cover property (state_cmd_o == dcw_pkg::CMD_ENOP);
endmodule
`default_nettype wire

// ---- sim/dcw_master_model.sv ----
/*
 * Fieldbus master model: issues object reads and writes as one-cycle
 * strobes. Assumes the decoder answers one cycle after each strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module dcw_master_model (
   input  wire logic        ref_clk_i,
   output logic             obj_wr_o,
   output logic             obj_rd_o,
   output logic      [15:0] obj_idx_o,
   output logic      [15:0] obj_wdata_o,
   input  wire logic [15:0] obj_rdata_i,
   input  wire logic        obj_ack_i,
   input  wire logic        obj_nak_i
);
   // Bus idle at time zero
   initial begin
      obj_wr_o    = 1'b0;
      obj_rd_o    = 1'b0;
      obj_idx_o   = 16'h0000;
      obj_wdata_o = 16'h0000;
   end

   // One access: strobe on a falling edge, answer taken a cycle later
   task automatic xfer(input logic wr, input logic [15:0] idx,
         input logic [15:0] data, output logic [15:0] rdata,
         output logic [1:0] resp);
      @(negedge ref_clk_i);
      obj_wr_o    = wr;
      obj_rd_o    = ~wr;
      obj_idx_o   = idx;
      obj_wdata_o = data;
      @(negedge ref_clk_i);
      // Ack or nak stands only in the cycle after the strobe edge
      rdata = obj_rdata_i;
      resp  = {obj_nak_i, obj_ack_i};
      // Released lines show the inverse so stale values cannot pass
      obj_wr_o    = 1'b0;
      obj_rd_o    = 1'b0;
      obj_idx_o   = ~idx;
      obj_wdata_o = ~data;
   endtask
endmodule
`default_nettype wire

// ---- sim/drive_control_word_decoder_tb.sv ----
/*
 * Self-checking bench of the control word decoder of axis A.
 * Assumes the master model for object traffic and a 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dcw_consts.svh"
module drive_control_word_decoder_tb;
   logic        ref_clk_i = 1'b0;
   logic        nrst_i;
   logic        obj_wr, obj_rd, obj_ack, obj_nak;
   logic [15:0] obj_idx, obj_wdata, obj_rdata;
   logic [7:0]  op_mode_i;
   logic [15:0] status_i, err_code_i, ctrl_word;
   logic        err_set_i, target_reached_i;
   logic [2:0]  state_cmd;
   logic        fault_reset, ptl, ntl, halt, pp_start, pp_rel;
   logic        pp_chain, pp_queued, hm_run, ip_en;
   int          fails = 0;
   int          checked = 0;

   dcw_decoder #(.AXIS_OFS(16'h0000), .CW_W(16)) dut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .obj_wr_i(obj_wr),
      .obj_rd_i(obj_rd), .obj_idx_i(obj_idx), .obj_wdata_i(obj_wdata),
      .obj_rdata_o(obj_rdata), .obj_ack_o(obj_ack), .obj_nak_o(obj_nak),
      .op_mode_i(op_mode_i), .status_i(status_i), .err_set_i(err_set_i),
      .err_code_i(err_code_i), .target_reached_i(target_reached_i),
      .ctrl_word_o(ctrl_word), .state_cmd_o(state_cmd),
      .fault_reset_o(fault_reset), .pos_tlim_en_o(ptl),
      .neg_tlim_en_o(ntl), .halt_o(halt), .pp_start_o(pp_start),
      .pp_relative_o(pp_rel), .pp_chain_o(pp_chain),
      .pp_queued_o(pp_queued), .homing_run_o(hm_run), .interp_en_o(ip_en));

   dcw_master_model u_mst (
      .ref_clk_i(ref_clk_i), .obj_wr_o(obj_wr), .obj_rd_o(obj_rd),
      .obj_idx_o(obj_idx), .obj_wdata_o(obj_wdata),
      .obj_rdata_i(obj_rdata), .obj_ack_i(obj_ack), .obj_nak_i(obj_nak));

   // 100 MHz clock
   always #5 ref_clk_i = ~ref_clk_i;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Read an object and judge data and response
   task automatic rd(input logic [15:0] idx, input logic [15:0] exp,
         input logic [1:0] resp_exp);
      logic [15:0] d;
      logic [1:0]  r;
      u_mst.xfer(1'b0, idx, 16'h0000, d, r);
      check(r, resp_exp);
      check(d, exp);
   endtask

   // Write the control word; returns once decode outputs have settled
   task automatic wcw(input logic [15:0] w);
      logic [15:0] d;
      logic [1:0]  r;
      u_mst.xfer(1'b1, `DCW_IDX_CTRL, w, d, r);
      check(r, 2'b01);
      check(ctrl_word, w);
      @(negedge ref_clk_i);
   endtask

   task automatic t_objects;
      logic [15:0] d;
      logic [1:0]  r;
      rd(`DCW_IDX_ERR, `DCW_ERR_RST, 2'b01);
      rd(`DCW_IDX_CTRL, `DCW_CTRL_RST, 2'b01);
      rd(`DCW_IDX_STAT, 16'h5A3C, 2'b01);
      u_mst.xfer(1'b1, `DCW_IDX_ERR, 16'h1111, d, r);
      check(r, 2'b10);
      rd(`DCW_IDX_CTRL + `DCW_AXIS_B_OFS, 16'h0000, 2'b10);
      // A fresh error event replaces the code
      err_code_i = 16'h0A5C;
      err_set_i  = 1'b1;
      // Event drops as the read strobe rises, the read follows at once
      fork
         @(negedge ref_clk_i) err_set_i = 1'b0;
         rd(`DCW_IDX_ERR, 16'h0A5C, 2'b01);
      join
   endtask

   task automatic t_state_cmd;
      logic [15:0] w [7] = '{16'h0000, 16'h0002, 16'h0006, 16'h000E,
                             16'h0007, 16'h000F, 16'h000D};
      logic [2:0]  e [7] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h1};
      for (int i = 0; i < 7; i++) begin
         wcw(w[i]);
         check(state_cmd, e[i]);
      end
   endtask

   task automatic t_fault_reset;
      wcw(16'h0000);
      wcw(16'h008F);
      check(fault_reset, 1'b1);
      check(state_cmd, 3'h0);
      @(negedge ref_clk_i);
      check(fault_reset, 1'b0);
      wcw(16'h008F);
      check(fault_reset, 1'b0);
      rd(`DCW_IDX_ERR, 16'h0A5C, 2'b01);
   endtask

   task automatic t_tlim;
      logic [15:0] w [4] = '{16'h1800, 16'h0800, 16'h1000, 16'hE400};
      for (int i = 0; i < 4; i++) begin
         wcw(w[i]);
         check(ptl, w[i][11]);
         check(ntl, w[i][12]);
      end
      check(state_cmd, 3'h1);
      rd(`DCW_IDX_CTRL, 16'hE400, 2'b01);
   endtask

   task automatic t_modes;
      logic [7:0]  m [8] = '{`DCW_MODE_PP, `DCW_MODE_PV, `DCW_MODE_PT,
         `DCW_MODE_HM, `DCW_MODE_IP, `DCW_MODE_CSP, `DCW_MODE_CSV,
         `DCW_MODE_CST};
      logic [15:0] w;
      logic        cyc;
      for (int i = 0; i < 8; i++) begin
         op_mode_i = m[i];
         cyc = (i > 4);
         // Cyclic modes keep the mode bits low
         w = cyc ? 16'h0000 : 16'h0010;
         wcw(w);
         check(halt, 1'b0);
         check(hm_run, m[i] == `DCW_MODE_HM);
         check(ip_en, m[i] == `DCW_MODE_IP);
         wcw(w | 16'h0100);
         check(halt, 1'b1);
         check(hm_run | ip_en, 1'b0);
         wcw(16'h0000);
      end
   endtask

   // Wait a bounded span for a set point start pulse
   task automatic wait_start(output logic seen, output logic [1:0] rc);
      seen = 1'b0;
      rc   = 2'b00;
      for (int i = 0; i < 8 && !seen; i++) begin
         @(negedge ref_clk_i);
         if (pp_start === 1'b1) begin
            seen = 1'b1;
            rc   = {pp_rel, pp_chain};
         end
      end
   endtask

   task automatic t_pp;
      logic       s;
      logic [1:0] rc;
      op_mode_i        = `DCW_MODE_PP;
      target_reached_i = 1'b0;
      wcw(16'h0010);
      check({pp_queued, pp_start}, 2'b10);
      target_reached_i = 1'b1;
      wait_start(s, rc);
      check({s, rc}, 3'b100);
      target_reached_i = 1'b0;
      wcw(16'h0000);
      wcw(16'h0030);
      check({pp_queued, pp_start}, 2'b01);
      wcw(16'h0000);
      wcw(16'h0250);
      check({pp_queued, pp_chain}, 2'b11);
      target_reached_i = 1'b1;
      wait_start(s, rc);
      check({s, rc}, 3'b111);
      @(negedge ref_clk_i);
      check(pp_queued, 1'b0);
   endtask

   // Watchdog well past the expected run of under two hundred cycles
   initial begin
      #200000;
      fails++;
      complete_run;
   end

   initial begin
      nrst_i           = 1'b0;
      op_mode_i        = `DCW_MODE_CSP;
      status_i         = 16'h5A3C;
      err_set_i        = 1'b0;
      err_code_i       = 16'h0000;
      target_reached_i = 1'b0;
      repeat (6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      nrst_i = 1'b1;
      check(ctrl_word, `DCW_CTRL_RST);
      t_objects;
      t_state_cmd;
      t_fault_reset;
      t_tlim;
      t_modes;
      t_pp;
      complete_run;
   end
endmodule
`default_nettype wire
